//--- core/ats_sequencer.sv
// Purpose: tuning sequencer for an automatic antenna matching network
// Assumes: comparator and line inputs are asynchronous and are synchronised here
// Notes:   registers over AXI4-Lite; search is a bounded walk of the relay code
// Functional notes
// - supply power-up resets controller, then initialization and coarse check begin
// - initialization drives tune key low to request low-power tune carrier
// - mismatch high at initialization starts the coarse search stage
// - mismatch low at initialization keeps elements until a channel change
// - each stage steps elements and samples mismatch once per settle period
// - coarse match saves element list and moves to mid stage
// - exhausted stage restores saved configuration and goes to termination
// - mid stage raises mid select; searches only if mismatch high
// - mid match saves element list and begins fine stage
// - fine stage drops mid select, raises fine select, searches while mismatch high
// - fine match saves list, drops fine select, proceeds to termination
// - termination releases tune key high and keeps element list
// - elements held until tune line, supply or channel change transition
// - A/B sense change in hold clears elements and restarts initialization
// - supply loss discards list; reapplying supply restarts initialization
// - half second after selection inputs rise, tuned falls, initialization runs
// - power outside window over two seconds during a coarse, mid or fine stage aborts and restores saved set
// - after abort restart only on channel change with power in range
// - short power excursion resumes the interrupted stage where it stopped
module ats_sequencer
    import ats_pkg::*;
#(
    parameter int unsigned EXCURSION_CYCLES = EXCURSION_CYC,
    parameter int unsigned SETTLE_CYCLES    = SETTLE_CYC
)(
    input  wire logic        core_clk_i,         // controller clock
    input  wire logic        sys_rst_i,          // sync reset, high
    input  wire logic        supply_ok_i,        // switched supply present (pin)
    input  wire logic        mismatch_in_i,      // mismatch comparator (pin)
    input  wire logic        phase_sense_in_i,   // phase sense (pin)
    input  wire logic        ab_sense_in_i,      // A/B channel sense (pin)
    input  wire logic        power_ack_pin_i,    // low when power in window (pin)
    input  wire logic        tuned_input_pin_i,  // channel change done, falls (pin)
    output logic             tune_key_out_o,     // low requests tune carrier
    output logic             mid_threshold_select_out_o,  // 2:1 select
    output logic             fine_threshold_select_out_o, // 1.5:1 select
    output ats_elem_s        elem_o,             // relay drive
    input  wire logic [31:0] s_axi_awaddr,       // write address
    input  wire logic        s_axi_awvalid,      // write address valid
    output logic             s_axi_awready,      // write address ready
    input  wire logic [31:0] s_axi_wdata,        // write data
    input  wire logic [3:0]  s_axi_wstrb,        // write strobes
    input  wire logic        s_axi_wvalid,       // write data valid
    output logic             s_axi_wready,       // write data ready
    output logic [1:0]       s_axi_bresp,        // write response
    output logic             s_axi_bvalid,       // write response valid
    input  wire logic        s_axi_bready,       // write response ready
    input  wire logic [31:0] s_axi_araddr,       // read address
    input  wire logic        s_axi_arvalid,      // read address valid
    output logic             s_axi_arready,      // read address ready
    output logic [31:0]      s_axi_rdata,        // read data
    output logic [1:0]       s_axi_rresp,        // read response
    output logic             s_axi_rvalid,       // read valid
    input  wire logic        s_axi_rready        // read ready
);
    localparam int unsigned CW = $clog2(EXCURSION_CYCLES + 1);
    localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);

    if (EXCURSION_CYCLES < 2 || SETTLE_CYCLES < 3)
    begin : g_chk
        $error("ats_sequencer: counts too small");
    end

    // =====================================================================
    // input synchronisers
    // =====================================================================
    localparam int unsigned NSYNC = 6;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    logic [NSYNC-1:0] prev_ff;
    logic             sup;
    logic             mis;
    logic             ab;
    logic             pwr_bad;
    logic             tuned;

    always_ff @(posedge core_clk_i)
    begin
        meta_ff <= {tuned_input_pin_i, power_ack_pin_i, ab_sense_in_i,
                    phase_sense_in_i, mismatch_in_i, supply_ok_i};
        sync_ff <= meta_ff;
        prev_ff <= sync_ff;
    end

    assign sup     = sync_ff[0];
    assign mis     = sync_ff[1];
    assign ab      = sync_ff[3];
    assign pwr_bad = sync_ff[4];
    assign tuned   = sync_ff[5];

    logic ab_edge;
    logic chan_done;
    logic sup_rise;
    assign ab_edge   = ab ^ prev_ff[3];
    assign chan_done = prev_ff[5] & ~tuned;
    assign sup_rise  = sup & ~prev_ff[0];

    // =====================================================================
    // control register
    // =====================================================================
    logic       start_ff;
    logic       soft_start;

    // =====================================================================
    // sequencer
    // =====================================================================
    ats_state_e      state_ff;
    ats_elem_s       cur_ff;
    ats_elem_s       saved_ff;
    logic [SW-1:0]   settle_ff;
    logic [CW-1:0]   exc_ff;
    logic            exc_long;
    logic            search;
    logic            settled;
    logic            exhausted;
    logic [ELEM_W-1:0] step_code;

    assign search    = (state_ff == ATS_COARSE) || (state_ff == ATS_MID)
                       || (state_ff == ATS_FINE);
    assign settled   = (settle_ff == '0);
    assign exhausted = (cur_ff == {ELEM_W{1'b1}});
    assign exc_long  = (exc_ff >= CW'(EXCURSION_CYCLES));
    assign step_code = cur_ff + ELEM_W'(1);

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || !pwr_bad || !search)
            exc_ff <= '0;
        else if (!exc_long)
            exc_ff <= exc_ff + CW'(1);
    end

    // comparator settle time after each relay, select or state change; relay
    // and select registers plus the pin synchroniser need three cycles
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || !sup || sup_rise || !(state_ff == ATS_INIT || search))
            settle_ff <= SW'(SETTLE_CYCLES);
        else if (!settled)
            settle_ff <= settle_ff - SW'(1);
        else if (!pwr_bad)
            settle_ff <= SW'(SETTLE_CYCLES);
    end

    always_ff @(posedge core_clk_i)
    begin
        // reset on supply application or loss
        if (sys_rst_i || !sup || sup_rise)
        begin
            state_ff  <= ATS_INIT;
            cur_ff    <= ELEM_RST;
            saved_ff  <= ELEM_RST;
        end
        else
        begin
            unique case (state_ff)
                ATS_INIT:
                begin
                    if (settled && !pwr_bad)
                        state_ff <= mis ? ATS_COARSE : ATS_TERM;
                end
                ATS_COARSE, ATS_MID, ATS_FINE:
                begin
                    if (exc_long)
                    begin
                        cur_ff   <= saved_ff;
                        state_ff <= ATS_ABORT;
                    end
                    else if (pwr_bad || !settled)
                        state_ff <= state_ff;
                    else if (!mis)
                    begin
                        saved_ff <= cur_ff;
                        state_ff <= (state_ff == ATS_COARSE) ? ATS_MID
                                  : (state_ff == ATS_MID) ? ATS_FINE : ATS_TERM;
                    end
                    else if (exhausted)
                    begin
                        cur_ff   <= saved_ff;
                        state_ff <= ATS_TERM;
                    end
                    else
                        cur_ff <= step_code;
                end
                ATS_TERM:
                    state_ff <= ATS_HOLD;
                ATS_HOLD:
                begin
                    if (ab_edge)
                    begin
                        cur_ff   <= ELEM_RST;
                        state_ff <= ATS_INIT;
                    end
                    else if (chan_done || soft_start)
                        state_ff <= ATS_INIT;
                end
                ATS_ABORT:
                begin
                    // restart needs change and good power
                    if ((chan_done || ab_edge) && !pwr_bad)
                        state_ff <= ATS_INIT;
                end
                default:
                    state_ff <= ATS_INIT;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            tune_key_out_o              <= 1'b1;
            mid_threshold_select_out_o  <= 1'b0;
            fine_threshold_select_out_o <= 1'b0;
            elem_o                      <= ELEM_RST;
        end
        else
        begin
            tune_key_out_o              <= !(state_ff == ATS_INIT || search);
            mid_threshold_select_out_o  <= (state_ff == ATS_MID);
            fine_threshold_select_out_o <= (state_ff == ATS_FINE);
            elem_o                      <= cur_ff;
        end
    end

    // =====================================================================
    // AXI4-Lite slave
    // =====================================================================
    logic [3:0] aw_ff;
    logic       aw_got_ff;
    logic [31:0] wd_ff;
    logic [3:0]  ws_ff;
    logic       w_got_ff;

    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign soft_start    = start_ff;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            aw_ff        <= '0;
            wd_ff        <= '0;
            ws_ff        <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            start_ff     <= 1'b0;
        end
        else
        begin
            start_ff <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ff     <= s_axi_awaddr[3:0];
                aw_got_ff <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wd_ff    <= s_axi_wdata;
                ws_ff    <= s_axi_wstrb;
                w_got_ff <= 1'b1;
            end
            if (aw_got_ff && w_got_ff)
            begin
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_ff == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
                start_ff     <= (aw_ff == OFS_CTRL) && ws_ff[0]
                                && wd_ff[CTRL_START_BIT];
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr[3:0])
                OFS_CTRL:   s_axi_rdata <= '0;
                OFS_STATUS: s_axi_rdata <= {19'h0, sync_ff, state_ff};
                OFS_ELEMS:  s_axi_rdata <= {11'h0, cur_ff};
                OFS_SAVED:  s_axi_rdata <= {11'h0, saved_ff};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // =====================================================================
    // assertions
    // =====================================================================
    a_key_released: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $past(state_ff) == ATS_HOLD |-> tune_key_out_o)
        else $error("tune key not released in hold");
    a_mid_select: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $past(state_ff) == ATS_MID |-> mid_threshold_select_out_o && !fine_threshold_select_out_o)
        else $error("mid select wrong");
    a_fine_select: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $past(state_ff) == ATS_FINE |-> fine_threshold_select_out_o && !mid_threshold_select_out_o)
        else $error("fine select wrong");
    a_abort_restore: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !sup)
        search && exc_long |=> state_ff == ATS_ABORT && cur_ff == $past(saved_ff))
        else $error("abort did not restore");
    a_ab_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !sup)
        state_ff == ATS_HOLD && ab_edge && !sup_rise |=> cur_ff == ELEM_RST)
        else $error("elements not cleared");
    a_supply_loss: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !sup |=> saved_ff == ELEM_RST && state_ff == ATS_INIT)
        else $error("list kept after supply loss");
    sequence s_power_pause;
        search && pwr_bad && !exc_long;
    endsequence
    sequence s_stage_held;
        state_ff == $past(state_ff) && cur_ff == $past(cur_ff);
    endsequence
    a_pause_holds: assert property (@(posedge core_clk_i) disable iff (sys_rst_i || !sup)
        s_power_pause |=> s_stage_held)
        else $error("stage moved during short power excursion");
    a_key_tuning: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) && ($past(state_ff) == ATS_INIT || $past(search)) |-> !tune_key_out_o)
        else $error("tune key not low while tuning");
endmodule // ats_sequencer

//--- core/ats_pkg.sv
// Purpose: shared constants and types for the antenna tuning sequencer
// Assumes: 200 MHz core clock
// Notes:   register map of the AXI4-Lite slave and search sizing
package ats_pkg;
    localparam int unsigned CLK_HZ          = 200_000_000;
    localparam int unsigned EXCURSION_MS    = 2000;
    localparam int unsigned EXCURSION_CYC   = (CLK_HZ / 1000) * EXCURSION_MS;
    localparam int unsigned SETTLE_US       = 1000;
    localparam int unsigned SETTLE_CYC      = (CLK_HZ / 1_000_000) * SETTLE_US;
    localparam int unsigned CAP_W           = 5;
    localparam int unsigned IND_W           = 10;
    localparam int unsigned ELEM_W          = 2 * CAP_W + IND_W + 1;
    localparam logic [ELEM_W-1:0] ELEM_RST  = '0;
    localparam logic [3:0]  OFS_CTRL        = 4'h0;
    localparam logic [3:0]  OFS_STATUS      = 4'h4;
    localparam logic [3:0]  OFS_ELEMS       = 4'h8;
    localparam logic [3:0]  OFS_SAVED       = 4'hc;
    localparam int unsigned CTRL_START_BIT  = 0;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef enum logic [6:0] {
        ATS_INIT    = 7'b0000001,
        ATS_COARSE  = 7'b0000010,
        ATS_MID     = 7'b0000100,
        ATS_FINE    = 7'b0001000,
        ATS_TERM    = 7'b0010000,
        ATS_HOLD    = 7'b0100000,
        ATS_ABORT   = 7'b1000000
    } ats_state_e;

    // element set: input caps, output caps, inductors, output inductor
    typedef struct packed {
        logic [CAP_W-1:0] cap_in;
        logic [CAP_W-1:0] cap_out;
        logic [IND_W-1:0] ind;
        logic             ind_out;
    } ats_elem_s;
endpackage : ats_pkg

//--- sim/ats_far_side.sv
// Purpose: far-side model of the radio tune line and analog detectors
// Assumes: mismatch clears once the relay code reaches the stage goal
// Notes:   the knob change is a busy level driven by the bench
module ats_far_side
    import ats_pkg::*;
(
    input  wire ats_elem_s         elem_i,       // relay drive
    input  wire logic              mid_sel_i,    // 2:1 select
    input  wire logic              fine_sel_i,   // 1.5:1 select
    input  wire logic              power_good_i, // tune power in window
    input  wire logic              knob_busy_i,  // knob change under way
    input  wire logic [ELEM_W-1:0] goal_c_i,     // 4:1 code
    input  wire logic [ELEM_W-1:0] goal_m_i,     // 2:1 code
    input  wire logic [ELEM_W-1:0] goal_f_i,     // 1.5:1 code
    output logic                   mismatch_o,   // comparator
    output logic                   phase_o,      // phase sense
    output logic                   power_ack_o,  // low in window
    output logic                   tuned_o       // falls when done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [ELEM_W-1:0] code;
    logic [ELEM_W-1:0] goal;

    assign code = elem_i;
    assign goal = fine_sel_i ? goal_f_i : (mid_sel_i ? goal_m_i : goal_c_i);
    assign mismatch_o = !knob_busy_i && (code < goal);
    assign phase_o = code < goal;
    assign power_ack_o = !knob_busy_i && !power_good_i;
    assign tuned_o = knob_busy_i;
endmodule // ats_far_side

//--- sim/tb.sv
// Purpose: self-checking bench for the tuning sequencer
// Assumes: far side answers from the relay code, stage selects and bench levels
// Notes:   excursion and settle counts are shortened by parameter
module tb
    import ats_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned EXC = 50;
    logic              core_clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              supply_ok = 1'b1, ab_sense = 1'b0;
    logic              power_good = 1'b1, knob_busy = 1'b0;
    logic [ELEM_W-1:0] tgt_c = '0, tgt_m = '0, tgt_f = '0;
    logic              mismatch, phase, power_ack, tuned, tune_key, mid_sel, fine_sel;
    ats_elem_s         elem;
    logic [31:0]       awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    int                miscompares = 0;
    int                checked = 0;
    int                i;

    always #2.5 core_clk_i = ~core_clk_i;

    ats_sequencer #(.EXCURSION_CYCLES(EXC), .SETTLE_CYCLES(4)) u_ats_sequencer (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok),
        .mismatch_in_i(mismatch), .phase_sense_in_i(phase), .ab_sense_in_i(ab_sense),
        .power_ack_pin_i(power_ack), .tuned_input_pin_i(tuned), .tune_key_out_o(tune_key),
        .mid_threshold_select_out_o(mid_sel), .fine_threshold_select_out_o(fine_sel),
        .elem_o(elem), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    ats_far_side u_ats_far_side (
        .elem_i(elem), .mid_sel_i(mid_sel), .fine_sel_i(fine_sel),
        .power_good_i(power_good), .knob_busy_i(knob_busy), .goal_c_i(tgt_c),
        .goal_m_i(tgt_m), .goal_f_i(tgt_f), .mismatch_o(mismatch), .phase_o(phase),
        .power_ack_o(power_ack), .tuned_o(tuned));

    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic hang;
        miscompares++;
        tally_and_finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    function automatic logic [31:0] ev();
        return 32'(elem);
    endfunction

    // next stage goal lies a random lo to 12 steps above the present one
    function automatic logic [31:0] goal(input logic [31:0] from, input int unsigned lo);
        return from + $urandom_range(12, lo);
    endfunction

    task automatic wait_on(input int sel, input logic lvl);
        int n;
        for (n = 0; n < 5000; n++)
        begin
            @(posedge core_clk_i);
            if ((sel == 0 ? tune_key : sel == 1 ? mid_sel : fine_sel) === lvl)
                return;
        end
        hang;
    endtask

    task automatic wr_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge core_clk_i);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge core_clk_i);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                bready <= 1'b0;
                cmp_word({30'h0, bresp}, {30'h0, r});
                return;
            end
        end
        hang;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        @(posedge core_clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge core_clk_i);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                rready <= 1'b0;
                cmp_word({30'h0, rresp}, {30'h0, r});
                if (r == RESP_OKAY)
                    cmp_word(rdata, d);
                return;
            end
        end
        hang;
    endtask

    // restart causes: 0 ab edge, 1 knob change, 2 register, 3 supply cycle
    task automatic kick(input int cause);
        @(posedge core_clk_i);
        case (cause)
            0: ab_sense <= ~ab_sense;
            1:
            begin
                knob_busy <= 1'b1;
                repeat (20) @(posedge core_clk_i);
                knob_busy <= 1'b0;
            end
            2: wr_chk({28'h0, OFS_CTRL}, 32'h1, RESP_OKAY);
            default:
            begin
                supply_ok <= 1'b0;
                repeat (8) @(posedge core_clk_i);
                cmp_word(ev(), 32'h0);
                supply_ok <= 1'b1;
            end
        endcase
    endtask

    task automatic tune_round(input int cause, input bit dip, input bit same);
        logic [31:0] c, m, f;
        c = goal(ev(), 1);
        m = same ? c : goal(c, 0);
        f = goal(m, 1);
        tgt_c <= ELEM_W'(c);
        tgt_m <= ELEM_W'(m);
        tgt_f <= ELEM_W'(f);
        kick(cause);
        wait_on(0, 1'b0);
        if (cause == 0)
            cmp_word(ev(), 32'h0);
        wait_on(1, 1'b1);
        cmp_bit(fine_sel, 1'b0);
        cmp_bit(ev() >= c, 1'b1);
        if (dip)
        begin
            power_good <= 1'b0;
            repeat (EXC - 30) @(posedge core_clk_i);
            power_good <= 1'b1;
        end
        wait_on(2, 1'b1);
        cmp_bit(mid_sel, 1'b0);
        cmp_bit(ev() >= m, 1'b1);
        wait_on(0, 1'b1);
        cmp_word(ev(), f);
        cmp_bit(fine_sel, 1'b0);
        rd_chk({28'h0, OFS_SAVED}, f, RESP_OKAY);
        repeat (100) @(posedge core_clk_i);
        cmp_word(ev(), f);
        rd_chk({28'h0, OFS_ELEMS}, f, RESP_OKAY);
        rd_chk({28'h0, OFS_STATUS}, {19'h0, 2'b00, ab_sense, 3'b001, ATS_HOLD}, RESP_OKAY);
    endtask

    initial
    begin
        void'($urandom(30));
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        cmp_bit(tune_key, 1'b1);
        wait_on(0, 1'b0);
        rd_chk({28'h0, OFS_CTRL}, 32'h0, RESP_OKAY);
        rd_chk(32'h6, 32'h0, RESP_SLVERR);
        wr_chk(32'h14, 32'h1, RESP_SLVERR);
        repeat (200) @(posedge core_clk_i);
        cmp_word(ev(), 32'h0);
        tune_round(0, 1'b0, 1'b1);
        for (i = 0; i < 6; i++)
            tune_round(i % 4, i % 2, 1'b0);
        tgt_c <= ELEM_W'(5);
        tgt_m <= ELEM_W'(9);
        tgt_f <= ELEM_W'(14);
        kick(0);
        wait_on(1, 1'b1);
        power_good <= 1'b0;
        repeat (EXC + 40) @(posedge core_clk_i);
        cmp_word(ev(), 32'd5);
        power_good <= 1'b1;
        repeat (100) @(posedge core_clk_i);
        cmp_word(ev(), 32'd5);
        tune_round(1, 1'b0, 1'b0);
        tally_and_finish;
    end
endmodule // tb
